// [ros_pkg.sv]
// Constants, types and configuration defaults for the receiver operation sequencer
// Overview of operation
// - After reset wait the selected crystal settling time, 78 to 2480 us, default 310.
// - Sleep timer, off by default, times sleep from 1 ms upward, default 10 ms.
// - Sleep interval applies in active mode, or passive mode with sleep timer on.
// - Receive timer, off by default, bounds receive window, default 1 ms.
// - Receive window applies in active mode, or passive mode with receive timer on.
// - Extended receive time, default 200 ms, used only with wake-on-radio and receive timer.
// - Wake-on-radio extends on preamble, or on preamble then sync; preamble is default.
// - Optional early exit leaves receive for standby or tune; off, standby by default.
// - Clock output pin carries divided system clock, 32 ratios, off by default.
// - Active mode uses stored configuration, passive uses host written; passive default.
// - Host loads configuration bank at start; bank is kept only until reset or power down.
// - Non-volatile configuration persists until reprogrammed.
// - Squelch threshold 0 to 255 suppresses noise, default 0.
// - On-off keying uses peak-tracking or constant threshold; peak-tracking default.
package ros_pkg;

  localparam int unsigned ROS_CLK_MHZ    = 10;
  localparam int unsigned ROS_MS_US      = 1000;
  localparam int unsigned ROS_RX_UNIT_US = 10;

  localparam int unsigned ROS_XTAL_US_0 = 78;
  localparam int unsigned ROS_XTAL_US_1 = 155;
  localparam int unsigned ROS_XTAL_US_2 = 310;
  localparam int unsigned ROS_XTAL_US_3 = 620;
  localparam int unsigned ROS_XTAL_US_4 = 1240;
  localparam int unsigned ROS_XTAL_US_5 = 2480;

  localparam int unsigned ROS_SLEEP_W = 27;
  localparam int unsigned ROS_RX_W    = 29;

  typedef enum logic [2:0] {
    st_settle,
    st_sleep,
    st_rx,
    st_standby,
    st_tune
  } ros_state_t;

  typedef struct packed {
    logic [2:0]             xtal_sel;
    logic                   sleep_en;
    logic [ROS_SLEEP_W-1:0] sleep_ms;
    logic                   rx_en;
    logic [ROS_RX_W-1:0]    rx_time;
    logic [ROS_RX_W-1:0]    rx_ext;
    logic                   early_exit_en;
    logic                   exit_to_tune;
    logic                   sysclk_out_pin_en;
    logic [4:0]             sysclk_out_pin_div;
    logic                   wor_en;
    logic                   wor_sync;
    logic                   ook_fixed;
    logic [7:0]             squelch;
    logic [7:0]             constant_threshold;
  } ros_cfg_t;

  localparam logic [2:0]             ROS_RST_XTAL_SEL = 3'h2;
  localparam logic [ROS_SLEEP_W-1:0] ROS_RST_SLEEP_MS = 27'h000000A;
  localparam logic [ROS_RX_W-1:0]    ROS_RST_RX_TIME  = 29'h00000064;
  localparam logic [ROS_RX_W-1:0]    ROS_RST_RX_EXT   = 29'h00004E20;
  localparam logic [4:0]             ROS_RST_SYSCLK_OUT_PIN_DIV = 5'h01;
  localparam logic [7:0]             ROS_RST_SQUELCH  = 8'h00;
  localparam logic [7:0]             ROS_RST_CONSTANT_THRESHOLD = 8'h32;

  localparam ros_cfg_t ROS_CFG_DEFAULT = '{
    xtal_sel: ROS_RST_XTAL_SEL, sleep_en: 1'b0, sleep_ms: ROS_RST_SLEEP_MS,
    rx_en: 1'b0, rx_time: ROS_RST_RX_TIME, rx_ext: ROS_RST_RX_EXT,
    early_exit_en: 1'b0, exit_to_tune: 1'b0, sysclk_out_pin_en: 1'b0,
    sysclk_out_pin_div: ROS_RST_SYSCLK_OUT_PIN_DIV, wor_en: 1'b0, wor_sync: 1'b0, ook_fixed: 1'b0,
    squelch: ROS_RST_SQUELCH, constant_threshold: ROS_RST_CONSTANT_THRESHOLD};

endpackage

// [ros_sequencer.sv]
// Receiver operation sequencer: settling, duty cycling, clock output, thresholds
`timescale 1ns/10ps
`default_nettype none
module ros_sequencer #(
  parameter int unsigned CYC_PER_US = ros_pkg::ROS_CLK_MHZ,
  parameter int unsigned MS_CYCLES  = ros_pkg::ROS_MS_US * ros_pkg::ROS_CLK_MHZ
) (
  // Clock and reset
  input  wire logic               ref_clk_in,
  input  wire logic               reset_n_in,
  // Configuration source
  input  wire logic               active_mode_in,
  input  wire ros_pkg::ros_cfg_t  nvm_cfg_in,
  input  wire logic               cfg_wr_in,
  input  wire ros_pkg::ros_cfg_t  cfg_wdata_in,
  // Radio events and requests
  input  wire logic               preamble_det_in,
  input  wire logic               sync_det_in,
  input  wire logic               rx_exit_req_in,
  input  wire logic               rx_req_in,
  input  wire logic               wake_req_in,
  input  wire logic [7:0]         rssi_in,
  // Sequencer status
  output ros_pkg::ros_state_t     state_out,
  output logic                    settled_out,
  output logic                    rx_on_out,
  output logic                    rx_extended_out,
  // Clock output and demodulator
  output logic                    sysclk_out_pin,
  output logic                    squelch_open_out,
  output logic                    ook_bit_out,
  output logic [7:0]              ook_threshold_out
);

  localparam int unsigned RX_UNIT_CYC = ros_pkg::ROS_RX_UNIT_US * CYC_PER_US;

  ros_pkg::ros_cfg_t   bank;
  ros_pkg::ros_cfg_t   cfg;
  ros_pkg::ros_state_t next_state;
  logic [ros_pkg::ROS_RX_W-1:0] timer;
  logic [ros_pkg::ROS_RX_W-1:0] next_timer;
  logic [15:0] settle_cnt;
  logic [15:0] settle_lim;
  logic [15:0] ms_cnt;
  logic [15:0] unit_cnt;
  logic        tick_ms;
  logic        tick_unit;
  logic        extended;
  logic        next_extended;
  logic        pre_seen;
  logic        sleep_timed;
  logic        rx_timed;
  logic        ext_ok;
  logic        ext_hit;
  logic [4:0]  div_cnt;
  logic [7:0]  peak;
  logic [7:0]  threshold;

  // Host bank, lost on power down
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      bank <= ros_pkg::ROS_CFG_DEFAULT;
    end else if (cfg_wr_in) begin
      bank <= cfg_wdata_in;
    end
  end

  // Stored or host configuration
  always_comb begin
    cfg = active_mode_in ? nvm_cfg_in : bank;
  end

  // Settling limit in cycles
  always_comb begin
    case (cfg.xtal_sel)
      3'h0:    settle_lim = 16'(ros_pkg::ROS_XTAL_US_0 * CYC_PER_US);
      3'h1:    settle_lim = 16'(ros_pkg::ROS_XTAL_US_1 * CYC_PER_US);
      3'h3:    settle_lim = 16'(ros_pkg::ROS_XTAL_US_3 * CYC_PER_US);
      3'h4:    settle_lim = 16'(ros_pkg::ROS_XTAL_US_4 * CYC_PER_US);
      3'h5:    settle_lim = 16'(ros_pkg::ROS_XTAL_US_5 * CYC_PER_US);
      default: settle_lim = 16'(ros_pkg::ROS_XTAL_US_2 * CYC_PER_US);
    endcase
  end

  // Millisecond and receive-unit ticks
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      ms_cnt    <= 16'h0000;
      unit_cnt  <= 16'h0000;
      tick_ms   <= 1'b0;
      tick_unit <= 1'b0;
    end else begin
      tick_ms   <= (ms_cnt == 16'(MS_CYCLES - 1));
      tick_unit <= (unit_cnt == 16'(RX_UNIT_CYC - 1));
      ms_cnt    <= (ms_cnt == 16'(MS_CYCLES - 1)) ? 16'h0000 : ms_cnt + 16'h0001;
      unit_cnt  <= (unit_cnt == 16'(RX_UNIT_CYC - 1)) ? 16'h0000 : unit_cnt + 16'h0001;
    end
  end

  // Timer qualifiers
  always_comb begin
    sleep_timed = active_mode_in | cfg.sleep_en;
    rx_timed    = active_mode_in | cfg.rx_en;
    ext_ok      = cfg.wor_en & cfg.rx_en;
    ext_hit     = cfg.wor_sync ? (sync_det_in & pre_seen) : preamble_det_in;
  end

  // Next state and timer
  always_comb begin
    next_state    = state_out;
    next_timer    = timer;
    next_extended = extended;
    case (state_out)
      ros_pkg::st_settle: begin
        if (settle_cnt >= settle_lim - 16'h0001) begin
          next_state    = ros_pkg::st_rx;
          next_timer    = cfg.rx_time;
          next_extended = 1'b0;
        end
      end
      ros_pkg::st_rx: begin
        if (cfg.early_exit_en && rx_exit_req_in) begin
          next_state = cfg.exit_to_tune ? ros_pkg::st_tune : ros_pkg::st_standby;
        end else if (ext_ok && !extended && ext_hit) begin
          next_timer    = cfg.rx_ext;
          next_extended = 1'b1;
        end else if (rx_timed && tick_unit) begin
          if (timer <= 29'h00000001) begin
            if (sleep_timed) begin
              next_state = ros_pkg::st_sleep;
              next_timer = {2'b00, cfg.sleep_ms};
            end else begin
              next_state = ros_pkg::st_standby;
            end
          end else begin
            next_timer = timer - 29'h00000001;
          end
        end
      end
      ros_pkg::st_sleep: begin
        if (sleep_timed) begin
          if (tick_ms) begin
            if (timer <= 29'h00000001) begin
              next_state    = ros_pkg::st_rx;
              next_timer    = cfg.rx_time;
              next_extended = 1'b0;
            end else begin
              next_timer = timer - 29'h00000001;
            end
          end
        end else if (wake_req_in) begin
          next_state    = ros_pkg::st_rx;
          next_timer    = cfg.rx_time;
          next_extended = 1'b0;
        end
      end
      ros_pkg::st_standby, ros_pkg::st_tune: begin
        if (rx_req_in) begin
          next_state    = ros_pkg::st_rx;
          next_timer    = cfg.rx_time;
          next_extended = 1'b0;
        end
      end
      default: begin
        next_state = ros_pkg::st_standby;
      end
    endcase
  end

  // Sequencer registers
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state_out       <= ros_pkg::st_settle;
      timer           <= '0;
      extended        <= 1'b0;
      settled_out     <= 1'b0;
      rx_on_out       <= 1'b0;
      rx_extended_out <= 1'b0;
    end else begin
      state_out       <= next_state;
      timer           <= next_timer;
      extended        <= next_extended;
      settled_out     <= settled_out | (next_state != ros_pkg::st_settle);
      rx_on_out       <= (next_state == ros_pkg::st_rx);
      rx_extended_out <= next_extended && (next_state == ros_pkg::st_rx);
    end
  end

  // Settling counter
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      settle_cnt <= 16'h0000;
    end else if (state_out == ros_pkg::st_settle) begin
      settle_cnt <= settle_cnt + 16'h0001;
    end
  end

  // Preamble seen in this receive window
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      pre_seen <= 1'b0;
    end else if (state_out != ros_pkg::st_rx) begin
      pre_seen <= 1'b0;
    end else if (preamble_det_in) begin
      pre_seen <= 1'b1;
    end
  end

  // System clock output divider
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      div_cnt        <= 5'h00;
      sysclk_out_pin <= 1'b0;
    end else if (!cfg.sysclk_out_pin_en) begin
      div_cnt        <= 5'h00;
      sysclk_out_pin <= 1'b0;
    end else if (div_cnt >= cfg.sysclk_out_pin_div) begin
      div_cnt        <= 5'h00;
      sysclk_out_pin <= ~sysclk_out_pin;
    end else begin
      div_cnt <= div_cnt + 5'h01;
    end
  end

  // Peak tracker with slow decay
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      peak <= 8'h00;
    end else if (rssi_in > peak) begin
      peak <= rssi_in;
    end else if (tick_unit && peak != 8'h00) begin
      peak <= peak - 8'h01;
    end
  end

  // Threshold selection
  always_comb begin
    if (cfg.ook_fixed) begin
      threshold = cfg.constant_threshold;
    end else if ({1'b0, peak[7:1]} > cfg.squelch) begin
      threshold = {1'b0, peak[7:1]};
    end else begin
      threshold = cfg.squelch;
    end
  end

  // Squelch and slicer
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      squelch_open_out  <= 1'b0;
      ook_bit_out       <= 1'b0;
      ook_threshold_out <= 8'h00;
    end else begin
      squelch_open_out  <= rssi_in > cfg.squelch;
      ook_bit_out       <= (rssi_in > cfg.squelch) && (rssi_in >= threshold);
      ook_threshold_out <= threshold;
    end
  end

endmodule
`default_nettype wire

// [ros_sequencer_properties.sv]
// Concurrent checks on the sequencer ports
`timescale 1ns/10ps
`default_nettype none
module ros_sequencer_properties (
  // Clock, reset and inputs
  input wire logic                ref_clk_in,
  input wire logic                reset_n_in,
  input wire logic                active_mode_in,
  input wire ros_pkg::ros_cfg_t   nvm_cfg_in,
  input wire logic                rx_exit_req_in,
  input wire logic [7:0]          rssi_in,
  // Outputs
  input wire ros_pkg::ros_state_t state_out,
  input wire logic                settled_out,
  input wire logic                rx_on_out,
  input wire logic                sysclk_out_pin,
  input wire logic                squelch_open_out,
  input wire logic                ook_bit_out,
  input wire logic [7:0]          ook_threshold_out
);
  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (!reset_n_in);
  // Stored configuration in use and unchanged
  sequence s_cfg_steady;
    active_mode_in ##1 active_mode_in && $stable(nvm_cfg_in);
  endsequence
  // Pin stays high one more cycle, then drops
  sequence s_high_pair;
    sysclk_out_pin ##1 !sysclk_out_pin;
  endsequence
  a_rx_flag: assert property (rx_on_out == (state_out == ros_pkg::st_rx))
    else $error("rx flag disagrees with state");
  a_settled_hold: assert property (settled_out |=> settled_out)
    else $error("settled flag dropped");
  a_settle_first: assert property (!settled_out |-> state_out == ros_pkg::st_settle)
    else $error("left settling before settled");
  a_sysclk_out_pin_off: assert property (s_cfg_steady ##0 !nvm_cfg_in.sysclk_out_pin_en |-> !sysclk_out_pin)
    else $error("clock pin active while disabled");
  a_sysclk_out_pin_rate: assert property (s_cfg_steady ##0 ($rose(sysclk_out_pin)
    && nvm_cfg_in.sysclk_out_pin_en && nvm_cfg_in.sysclk_out_pin_div == 5'h01) |=> s_high_pair)
    else $error("clock pin period wrong");
  a_squelch_cmp: assert property (s_cfg_steady
    |-> squelch_open_out == ($past(rssi_in) > nvm_cfg_in.squelch))
    else $error("squelch decision wrong");
  a_constant_threshold: assert property (s_cfg_steady ##0 nvm_cfg_in.ook_fixed
    |-> ook_threshold_out == nvm_cfg_in.constant_threshold)
    else $error("fixed threshold not used");
  a_ook_gate: assert property (ook_bit_out |-> squelch_open_out)
    else $error("data passed a closed squelch");
  a_exit_target: assert property (state_out == ros_pkg::st_rx && rx_exit_req_in
    && active_mode_in && nvm_cfg_in.early_exit_en && $stable(nvm_cfg_in)
    |-> ##[1:2] state_out == (nvm_cfg_in.exit_to_tune ? ros_pkg::st_tune : ros_pkg::st_standby))
    else $error("early exit target wrong");
  a_rx_to_sleep: assert property ($fell(rx_on_out) && active_mode_in && $past(active_mode_in)
    && !$past(rx_exit_req_in) && !$past(rx_exit_req_in, 2) |-> state_out == ros_pkg::st_sleep)
    else $error("active receive did not end in sleep");
endmodule
bind ros_sequencer ros_sequencer_properties ros_sequencer_properties_i (
  .ref_clk_in, .reset_n_in, .active_mode_in, .nvm_cfg_in, .rx_exit_req_in, .rssi_in,
  .state_out, .settled_out, .rx_on_out, .sysclk_out_pin, .squelch_open_out, .ook_bit_out,
  .ook_threshold_out
);
`default_nettype wire

// [ros_host_model.sv]
// Host model that loads the configuration bank
`timescale 1ns/10ps
`default_nettype none
module ros_host_model (
  // Clock and bank write
  input  wire logic               ref_clk_in,
  output var  logic               cfg_wr_out,
  output var  ros_pkg::ros_cfg_t  cfg_wdata_out
);
  initial cfg_wr_out = 1'b0;
  initial cfg_wdata_out = ros_pkg::ROS_CFG_DEFAULT;
  // Whole bank in one pulse, data scrambled afterwards
  task automatic load(input ros_pkg::ros_cfg_t v);
    @(posedge ref_clk_in);
    cfg_wr_out <= 1'b1;
    cfg_wdata_out <= v;
    @(posedge ref_clk_in);
    cfg_wr_out <= 1'b0;
    cfg_wdata_out <= ~v;
  endtask
endmodule
`default_nettype wire

// [test_receiver_operation_sequencer.sv]
// Self-checking bench for the receiver operation sequencer
`timescale 1ns/10ps
`default_nettype none
module test_receiver_operation_sequencer;
  localparam int UNIT = 10;
  localparam int MS   = 20;
  logic                clk, rst_n, act, cfg_wr, pre, syn, ex, rxr, wake;
  logic                settled, rxon, rxext, pin, sqo, ookb;
  logic [7:0]          rssi, th;
  ros_pkg::ros_cfg_t   nvm, cfg_wd, c;
  ros_pkg::ros_state_t st;
  int                  failures, cmp_count, n;
  ros_host_model ros_host_model_i (.ref_clk_in(clk), .cfg_wr_out(cfg_wr), .cfg_wdata_out(cfg_wd));
  ros_sequencer #(.CYC_PER_US(1), .MS_CYCLES(MS)) ros_sequencer_i (
    .ref_clk_in(clk), .reset_n_in(rst_n), .active_mode_in(act), .nvm_cfg_in(nvm),
    .cfg_wr_in(cfg_wr), .cfg_wdata_in(cfg_wd), .preamble_det_in(pre), .sync_det_in(syn),
    .rx_exit_req_in(ex), .rx_req_in(rxr), .wake_req_in(wake), .rssi_in(rssi),
    .state_out(st), .settled_out(settled), .rx_on_out(rxon), .rx_extended_out(rxext),
    .sysclk_out_pin(pin), .squelch_open_out(sqo), .ook_bit_out(ookb), .ook_threshold_out(th));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task automatic note(input bit ok);
    cmp_count++;
    if (!ok) begin
      failures++;
      $display("[ERR] %0t mismatch", $time);
    end
  endtask
  task automatic chk_st(input ros_pkg::ros_state_t e);
    note(st === e);
  endtask
  task automatic chk_b(input logic g, input logic e);
    note(g === e);
  endtask
  task automatic chk_n(input int g, input int lo, input int hi);
    note(g >= lo && g <= hi);
  endtask
  task automatic wait_st(input ros_pkg::ros_state_t s, input bit in, output int k);
    k = 0;
    while ((st === s) != in && k < 5000) begin
      @(negedge clk);
      k++;
    end
    if (k >= 5000) begin
      failures++;
      $display("[ERR] %0t state wait limit", $time);
    end
  endtask
  task automatic pulse(input int k);
    @(posedge clk);
    {syn, pre, ex, rxr} <= 4'h1 << k;
    @(posedge clk);
    {syn, pre, ex, rxr} <= 4'h0;
    repeat (2) @(negedge clk);
  endtask
  task automatic put;
    @(posedge clk);
    nvm <= c;
    ros_host_model_i.load(c);
    @(negedge clk);
  endtask
  task automatic exit_case(input logic en, input logic tune, input ros_pkg::ros_state_t e);
    c.early_exit_en = en;
    c.exit_to_tune = tune;
    put();
    if (st !== ros_pkg::st_rx) pulse(0);
    pulse(1);
    chk_st(e);
  endtask
  task automatic do_reset;
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (11) @(posedge clk);
    @(negedge clk);
    chk_b(settled, 1'b0);
    chk_st(ros_pkg::st_settle);
    @(posedge clk);
    rst_n <= 1'b1;
    wait_st(ros_pkg::st_rx, 1, n);
    chk_n(n, 308, 312);
    chk_b(settled, 1'b1);
    chk_b(rxon, 1'b1);
  endtask
  task automatic t_idle;
    repeat (200) @(negedge clk);
    chk_st(ros_pkg::st_rx);
    chk_b(pin, 1'b0);
    chk_b(sqo, 1'b1);
    chk_b(ookb, 1'b1);
    chk_b(th === 8'h02, 1'b1);
  endtask
  task automatic t_wake;
    c.sleep_en = 1'b0;
    put();
    repeat (60) @(negedge clk);
    chk_st(ros_pkg::st_sleep);
    @(posedge clk);
    wake <= 1'b1;
    @(posedge clk);
    wake <= 1'b0;
    repeat (2) @(negedge clk);
    chk_st(ros_pkg::st_rx);
    chk_b(rxon, 1'b1);
    c.sleep_en = 1'b1;
    put();
  endtask
  task automatic t_duty;
    c.rx_en = 1'b1;
    c.rx_time = 29'h3;
    put();
    pulse(0);
    wait_st(ros_pkg::st_rx, 0, n);
    chk_n(n, 2 * UNIT, 3 * UNIT);
    chk_st(ros_pkg::st_standby);
    chk_b(rxon, 1'b0);
    c.sleep_en = 1'b1;
    c.sleep_ms = 27'h2;
    put();
    pulse(0);
    wait_st(ros_pkg::st_rx, 0, n);
    chk_st(ros_pkg::st_sleep);
    wait_st(ros_pkg::st_sleep, 0, n);
    chk_n(n, MS, 2 * MS);
  endtask
  task automatic t_wor;
    c.wor_en = 1'b1;
    c.rx_ext = 29'h14;
    for (int s = 0; s < 2; s++) begin
      c.wor_sync = s[0];
      put();
      wait_st(ros_pkg::st_sleep, 1, n);
      wait_st(ros_pkg::st_rx, 1, n);
      pulse(2);
      chk_b(rxext, !s[0]);
      if (s == 1) pulse(3);
      wait_st(ros_pkg::st_rx, 0, n);
      chk_n(n, 19 * UNIT, 20 * UNIT);
    end
  endtask
  task automatic t_active;
    int   k;
    logic p;
    c = ros_pkg::ROS_CFG_DEFAULT;
    c.sysclk_out_pin_en = 1'b1;
    c.ook_fixed = 1'b1;
    c.constant_threshold = 8'h40;
    c.squelch = 8'h20;
    @(posedge clk);
    act <= 1'b1;
    repeat (4) @(negedge clk);
    chk_b(pin, 1'b0);
    for (int d = 1; d >= 0; d--) begin
      c.sysclk_out_pin_div = 5'(d);
      put();
      p = pin;
      k = 0;
      repeat (40) begin
        @(negedge clk);
        k += int'(pin !== p);
        p = pin;
      end
      chk_n(k, 40 / (d + 1) - 1, 40 / (d + 1) + 1);
    end
    for (int i = 1; i < 6; i += 2) begin
      @(posedge clk);
      rssi <= 8'(i * 16);
      repeat (2) @(negedge clk);
      chk_b(sqo, i * 16 > 32);
      chk_b(ookb, i * 16 >= 64);
      chk_b(th === 8'h40, 1'b1);
    end
    wait_st(ros_pkg::st_rx, 1, n);
    wait_st(ros_pkg::st_rx, 0, n);
    chk_st(ros_pkg::st_sleep);
    wait_st(ros_pkg::st_rx, 1, n);
    exit_case(1'b1, 1'b0, ros_pkg::st_standby);
    @(posedge clk);
    act <= 1'b0;
    rssi <= 8'h05;
  endtask
  task automatic conclude;
    $display("failures=%0d comparisons=%0d", failures, cmp_count);
    if (failures == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    {rst_n, act, pre, syn, ex, rxr, wake} = 7'h00;
    nvm = ros_pkg::ROS_CFG_DEFAULT;
    rssi = 8'h05;
    failures = 0;
    cmp_count = 0;
    c = ros_pkg::ROS_CFG_DEFAULT;
    do_reset();
    t_idle();
    exit_case(1'b1, 1'b1, ros_pkg::st_tune);
    exit_case(1'b0, 1'b0, ros_pkg::st_rx);
    exit_case(1'b1, 1'b0, ros_pkg::st_standby);
    t_duty();
    t_wor();
    t_wake();
    t_active();
    do_reset();
    t_idle();
    conclude();
  end
  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    conclude();
  end
endmodule
`default_nettype wire
